// file: hdl/iseq_core.sv
// Purpose: instruction sequencer with program counter and return stack
// Assumes: program memory returns data one clock after its read strobe
// Notes: decoder flow controls are sampled at T4 of the execute cycle
// Notes on behaviour
// - clock split into four phases per cycle
// - T1 advances counter and starts fetch
// - T2 to T4 decode and execute held word
// - fetch overlaps execute, one per cycle
// - jumps and calls flush, take two cycles
// - met skip discards prefetch, dummy cycle
// - counter steps by one otherwise
// - full target loaded on branch, irq, reset
// - thirteen-bit counter, low byte writable, whole counter readable
// - low byte readable and writable
// - low byte write jumps within page
// - low byte write inserts dummy cycle
// - eight-level stack, contents not software visible
// - call or irq acknowledge pushes prefetched address
// - returns pop counter from stack
// - reset empties stack pointer
// - full stack latches irq, withholds acknowledge
// - call on full stack drops oldest
// - reset starts fetch at address zero
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iseq_core
    import iseq_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // program memory
    output logic [PC_W-1:0] pm_addr,
    output logic pm_rd,
    input wire logic [INSTR_W-1:0] pm_data,
    // instruction decoder
    output logic [INSTR_W-1:0] instr,
    output logic instr_valid,
    output logic [1:0] phase,
    output logic [PCL_W-1:0] pc_low_byte,
    input wire logic dec_jump,
    input wire logic dec_call,
    input wire logic dec_ret,
    input wire logic dec_interrupt_return,
    input wire logic dec_skip,
    input wire logic dec_pcl_wr,
    input wire logic [PCL_W-1:0] dec_pcl_data,
    input wire logic [PC_W-1:0] dec_target,
    // interrupt logic
    input wire logic irq_req,
    input wire logic [PC_W-1:0] irq_vector,
    output logic irq_ack,
    output logic interrupt_return_done
);
    iseq_int_if ib ();

    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [PC_W-1:0] fetch_addr_q;
    logic [PC_W-1:0] pm_addr_q;
    logic pm_rd_q;
    logic [INSTR_W-1:0] fetch_ir_q;
    logic fetch_v_q;
    logic [INSTR_W-1:0] exec_ir_q;
    logic exec_v_q;
    logic run_q;
    logic ovf_q;
    logic irq_pend_q;
    logic irq_ack_q;
    logic interrupt_return_q;
    logic [PCL_W-1:0] spcl_q;
    logic spcl_pend_q;
    logic [31:0] prdata_q;
    logic exec_go;
    logic do_ret;
    logic do_call;
    logic do_jmp;
    logic do_dpcl;
    logic do_skip;
    logic do_spcl;
    logic do_irq;
    logic flow;
    logic flush;
    logic apb_wr;
    logic apb_setup;
    logic mapped;
    logic [31:0] rd_mux;

    // ========================================
    // submodules
    iseq_phase u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .bus(ib.phs)
    );

    iseq_stack u_stack (
        .pclk(pclk),
        .presetn(presetn),
        .bus(ib.stk)
    );

    assign ib.run = run_q;

    // ========================================
    // flow decisions at end of execute cycle
    assign exec_go = exec_v_q && ib.t4;
    assign do_ret = exec_go && (dec_ret || dec_interrupt_return);
    assign do_call = exec_go && dec_call && !do_ret;
    assign do_jmp = exec_go && dec_jump && !do_ret && !do_call;
    assign do_dpcl = exec_go && dec_pcl_wr && !do_ret && !do_call && !do_jmp;
    assign flow = do_ret || do_call || do_jmp || do_dpcl;
    assign do_skip = exec_go && dec_skip && !flow;
    // software writes wait for a cycle free of other flow changes
    assign do_spcl = ib.t4 && spcl_pend_q && !flow && !do_skip;
    // a full stack holds the request off until a return frees a level
    assign do_irq = ib.t4 && irq_pend_q && !ib.full && !flow && !do_skip
        && !do_spcl;
    assign flush = flow || do_skip || do_spcl || do_irq;

    // ========================================
    // stack control
    assign ib.push = do_call || do_irq;
    assign ib.pop = do_ret;
    // the prefetched address is the one not yet executed
    assign ib.push_data = fetch_addr_q;

    // ========================================
    // next program counter
    always_comb begin
        pc_d = pc_q;
        if (do_ret) begin
            pc_d = ib.pop_data;
        end else if (do_call || do_jmp) begin
            pc_d = dec_target;
        end else if (do_dpcl) begin
            pc_d = {pc_q[PC_W-1:PCL_W], dec_pcl_data};
        end else if (do_spcl) begin
            pc_d = {pc_q[PC_W-1:PCL_W], spcl_q};
        end else if (do_irq) begin
            pc_d = irq_vector;
        end else if (ib.t1) begin
            pc_d = pc_q + 13'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= RESET_PC;
        end else begin
            pc_q <= pc_d;
        end
    end

    // ========================================
    // fetch stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_addr_q <= RESET_PC;
            pm_rd_q <= 1'b0;
            fetch_addr_q <= RESET_PC;
            fetch_ir_q <= 16'h0000;
            fetch_v_q <= 1'b0;
        end else begin
            pm_rd_q <= ib.t1;
            if (ib.t1) begin
                pm_addr_q <= pc_q;
                fetch_addr_q <= pc_q;
                fetch_v_q <= 1'b1;
            end
            // memory answers one clock after the strobe, so the word stands in T3
            if (run_q && (ib.phase == PH_T3)) begin
                fetch_ir_q <= pm_data;
            end
        end
    end

    // ========================================
    // execute stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_ir_q <= 16'h0000;
            exec_v_q <= 1'b0;
        end else if (ib.t4) begin
            exec_ir_q <= fetch_ir_q;
            exec_v_q <= fetch_v_q && !flush;
        end
    end

    // ========================================
    // interrupt hand-off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pend_q <= 1'b0;
            irq_ack_q <= 1'b0;
            interrupt_return_q <= 1'b0;
        end else begin
            irq_ack_q <= do_irq;
            interrupt_return_q <= do_ret && dec_interrupt_return;
            // a new request in the acknowledge cycle stays latched
            if (irq_req) begin
                irq_pend_q <= 1'b1;
            end else if (do_irq) begin
                irq_pend_q <= 1'b0;
            end
        end
    end

    // ========================================
    // apb register file
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign mapped = (paddr == ADDR_PCL) || (paddr == ADDR_CTRL)
        || (paddr == ADDR_STAT) || (paddr == ADDR_PC);

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ADDR_PCL: rd_mux[PCL_W-1:0] = pc_q[PCL_W-1:0];
            ADDR_CTRL: rd_mux[CTRL_RUN_BIT] = run_q;
            ADDR_STAT: begin
                rd_mux[STAT_LVL_LSB +: LVL_W] = ib.level;
                rd_mux[STAT_FULL_BIT] = ib.full;
                rd_mux[STAT_OVF_BIT] = ovf_q;
                rd_mux[STAT_IRQP_BIT] = irq_pend_q;
                rd_mux[STAT_DUMMY_BIT] = !exec_v_q;
                rd_mux[STAT_PH_LSB +: 2] = ib.phase;
            end
            ADDR_PC: rd_mux[PC_W-1:0] = pc_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data is latched in setup so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= CTRL_RUN_RST;
        end else if (apb_wr && (paddr == ADDR_CTRL)) begin
            run_q <= pwdata[CTRL_RUN_BIT];
        end
    end

    // the write is held until a T4 so it acts as a page jump
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spcl_q <= 8'h00;
            spcl_pend_q <= 1'b0;
        end else if (apb_wr && (paddr == ADDR_PCL)) begin
            spcl_q <= pwdata[PCL_W-1:0];
            spcl_pend_q <= 1'b1;
        end else if (do_spcl) begin
            spcl_pend_q <= 1'b0;
        end
    end

    // overflow is sticky, write one to clear, a new overflow wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else if (ib.ovf) begin
            ovf_q <= 1'b1;
        end else if (apb_wr && (paddr == ADDR_STAT) && pwdata[STAT_OVF_BIT]) begin
            ovf_q <= 1'b0;
        end
    end

    // ========================================
    // outputs
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign pm_addr = pm_addr_q;
    assign pm_rd = pm_rd_q;
    assign instr = exec_ir_q;
    assign instr_valid = exec_v_q;
    assign phase = ib.phase;
    assign pc_low_byte = pc_q[PCL_W-1:0];
    assign irq_ack = irq_ack_q;
    assign interrupt_return_done = interrupt_return_q;
    // stack contents and level are deliberately kept off every port
    // except the status word, whose only writable bit clears overflow
endmodule
`default_nettype wire

// file: hdl/iseq_pkg.sv
// Purpose: shared constants and types of the instruction sequencer
// Assumes: one 40 MHz clock, APB register access
// Notes: register offsets are byte addresses
package iseq_pkg;
    // ========================================
    // widths
    localparam int PC_W = 13;
    localparam int PCL_W = 8;
    localparam int PAGE_W = 5;
    localparam int INSTR_W = 16;
    localparam int STK_DEPTH = 8;
    localparam int STK_IDX_W = 3;
    localparam int LVL_W = 4;
    localparam int APB_AW = 8;
    // ========================================
    // reset values and stack limit
    localparam logic [PC_W-1:0] RESET_PC = 13'h0000;
    localparam logic [LVL_W-1:0] LVL_EMPTY = 4'h0;
    localparam logic [LVL_W-1:0] LVL_FULL = 4'h8;
    localparam logic CTRL_RUN_RST = 1'b1;
    // ========================================
    // register map
    localparam logic [APB_AW-1:0] ADDR_PCL = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_STAT = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_PC = 8'h0C;
    // ========================================
    // field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int STAT_LVL_LSB = 0;
    localparam int STAT_FULL_BIT = 4;
    localparam int STAT_OVF_BIT = 5;
    localparam int STAT_IRQP_BIT = 6;
    localparam int STAT_DUMMY_BIT = 7;
    localparam int STAT_PH_LSB = 8;
    // ========================================
    // instruction cycle phases
    typedef enum logic [1:0] {
        PH_T1 = 2'b00,
        PH_T2 = 2'b01,
        PH_T3 = 2'b10,
        PH_T4 = 2'b11
    } iseq_phase_t;
endpackage

// file: hdl/iseq_int_if.sv
// Purpose: internal carrier between sequencer core, phase divider and stack
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface iseq_int_if;
    import iseq_pkg::*;
    // phase divider
    logic run;
    logic t1;
    logic t2;
    logic t4;
    iseq_phase_t phase;
    // return stack
    logic push;
    logic pop;
    logic [PC_W-1:0] push_data;
    logic [PC_W-1:0] pop_data;
    logic [LVL_W-1:0] level;
    logic full;
    logic ovf;
    modport phs (input run, output t1, output t2, output t4, output phase);
    modport stk (input push, input pop, input push_data,
        output pop_data, output level, output full, output ovf);
    modport core (output run, input t1, input t2, input t4, input phase,
        output push, output pop, output push_data,
        input pop_data, input level, input full, input ovf);
endinterface
`default_nettype wire

// file: hdl/iseq_phase.sv
// Purpose: four-phase instruction cycle divider
// Assumes: run gates the whole sequence
// Notes: phase strobes are one-cycle enables, no derived clocks
`timescale 1ns/1ps
`default_nettype none
module iseq_phase
    import iseq_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // carrier
    iseq_int_if.phs bus
);
    iseq_phase_t ph_q;

    // ========================================
    // phase counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= PH_T1;
        end else if (bus.run) begin
            unique case (ph_q)
                PH_T1: ph_q <= PH_T2;
                PH_T2: ph_q <= PH_T3;
                PH_T3: ph_q <= PH_T4;
                PH_T4: ph_q <= PH_T1;
            endcase
        end
    end

    assign bus.phase = ph_q;
    assign bus.t1 = bus.run && (ph_q == PH_T1);
    assign bus.t2 = bus.run && (ph_q == PH_T2);
    assign bus.t4 = bus.run && (ph_q == PH_T4);
endmodule
`default_nettype wire

// file: hdl/iseq_stack.sv
// Purpose: eight-level return stack for program counter values
// Assumes: push and pop never in the same cycle
// Notes: circular store, so a push when full drops the oldest entry
`timescale 1ns/1ps
`default_nettype none
module iseq_stack
    import iseq_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // carrier
    iseq_int_if.stk bus
);
    logic [PC_W-1:0] mem [STK_DEPTH];
    logic [STK_IDX_W-1:0] top_q;
    logic [LVL_W-1:0] lvl_q;
    logic ovf_q;
    logic [STK_IDX_W-1:0] rd_idx;

    assign rd_idx = top_q - 3'h1;

    // ========================================
    // storage
    always_ff @(posedge pclk) begin
        if (bus.push) begin
            mem[top_q] <= bus.push_data;
        end
    end

    // ========================================
    // level pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_q <= 3'h0;
            lvl_q <= LVL_EMPTY;
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= bus.push && (lvl_q == LVL_FULL);
            if (bus.push) begin
                top_q <= top_q + 3'h1;
                if (lvl_q != LVL_FULL) begin
                    lvl_q <= lvl_q + 4'h1;
                end
            end else if (bus.pop) begin
                top_q <= rd_idx;
                if (lvl_q != LVL_EMPTY) begin
                    lvl_q <= lvl_q - 4'h1;
                end
            end
        end
    end

    assign bus.pop_data = mem[rd_idx];
    assign bus.level = lvl_q;
    assign bus.full = (lvl_q == LVL_FULL);
    assign bus.ovf = ovf_q;
endmodule
`default_nettype wire

// file: testbench/iseq_core_chk.sv
// Purpose: timing checker for the sequencer top ports
// Assumes: one clock, presetn async active low
// Notes: decoder controls count only in a valid T4 cycle
`timescale 1ns/1ps
`default_nettype none
module iseq_core_chk
    import iseq_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // fetch and execute
    input wire logic [PC_W-1:0] pm_addr,
    input wire logic pm_rd,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic instr_valid,
    input wire logic [1:0] phase,
    input wire logic [PCL_W-1:0] pc_low_byte,
    // decoder and interrupt
    input wire logic dec_jump,
    input wire logic dec_call,
    input wire logic dec_ret,
    input wire logic dec_interrupt_return,
    input wire logic dec_skip,
    input wire logic dec_pcl_wr,
    input wire logic [PCL_W-1:0] dec_pcl_data,
    input wire logic [PC_W-1:0] dec_target,
    input wire logic [PC_W-1:0] irq_vector,
    input wire logic irq_ack,
    input wire logic interrupt_return_done
);
    // ========
    // helpers
    logic t4v;
    logic hi;
    assign t4v = instr_valid && phase == 2'd3;
    // returns and calls outrank jumps and low byte writes
    assign hi = dec_ret || dec_interrupt_return || dec_call;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========
    // assertions
    AST_PHASE_STEP: assert property ($changed(phase) |-> phase == 2'($past(phase) + 2'd1))
        else $error("phase out of order");
    AST_FETCH_T2: assert property (pm_rd |-> phase == 2'd1)
        else $error("fetch outside T2");
    AST_FETCH_GAP: assert property (pm_rd |=> !pm_rd [*3])
        else $error("fetch strobes too close");
    AST_PC_AHEAD: assert property (pm_rd |-> pc_low_byte == 8'(pm_addr[7:0] + 8'h01))
        else $error("counter not one ahead of fetch");
    AST_HOLD: assert property (phase != 2'd0 |-> $stable(instr) && $stable(instr_valid))
        else $error("held word changed mid cycle");
    AST_JUMP_FLUSH: assert property (t4v && (dec_jump || dec_call) |=> !instr_valid)
        else $error("no flush after branch");
    AST_SKIP_FLUSH: assert property (t4v && dec_skip |=> !instr_valid)
        else $error("no dummy after skip");
    AST_PCL_FLUSH: assert property (t4v && dec_pcl_wr |=> !instr_valid)
        else $error("no dummy after low byte write");
    AST_JUMP_TARGET: assert property (t4v && dec_jump && !hi
        |-> ##2 pm_rd && pm_addr == $past(dec_target, 2))
        else $error("jump target not fetched");
    AST_PCL_TARGET: assert property (t4v && dec_pcl_wr && !hi && !dec_jump
        |-> ##2 pm_rd && pm_addr[7:0] == $past(dec_pcl_data, 2))
        else $error("low byte target not fetched");
    AST_IRQ_VECTOR: assert property (irq_ack |-> ##1 pm_rd && pm_addr == $past(irq_vector, 2))
        else $error("vector not fetched after ack");
    AST_INTERRUPT_RETURN_PULSE: assert property (t4v && dec_interrupt_return |=> interrupt_return_done ##1 !interrupt_return_done)
        else $error("missing interrupt_return pulse");
    // ========
    // coverage
    cover property (t4v && dec_call);
    cover property (t4v && dec_skip);
    cover property (irq_ack);
endmodule
bind iseq_core iseq_core_chk chk_i (.pclk, .presetn, .pm_addr, .pm_rd, .instr, .instr_valid,
    .phase, .pc_low_byte, .dec_jump, .dec_call, .dec_ret, .dec_interrupt_return, .dec_skip, .dec_pcl_wr,
    .dec_pcl_data, .dec_target, .irq_vector, .irq_ack, .interrupt_return_done);
`default_nettype wire

// file: testbench/iseq_partner.sv
// Purpose: program memory and decoder model
// Assumes: op code in word bits 15:13, target in 12:0
// Notes: skips are always taken, so every skip costs a dummy cycle
`timescale 1ns/1ps
`default_nettype none
module iseq_partner
    import iseq_pkg::*;
(
    // clock
    input wire logic pclk,
    // program memory
    input wire logic [PC_W-1:0] pm_addr,
    output logic [INSTR_W-1:0] pm_data,
    // decoder
    input wire logic [INSTR_W-1:0] instr,
    input wire logic instr_valid,
    output logic dec_jump,
    output logic dec_call,
    output logic dec_ret,
    output logic dec_interrupt_return,
    output logic dec_skip,
    output logic dec_pcl_wr,
    output logic [PCL_W-1:0] dec_pcl_data,
    output logic [PC_W-1:0] dec_target
);
    // ========
    // synchronous memory, one clock latency
    logic [INSTR_W-1:0] mem [8192];
    logic [2:0] op;
    always_ff @(posedge pclk) begin
        pm_data <= mem[pm_addr];
    end
    // ========
    // decoder
    assign op = instr[15:13];
    assign dec_jump = instr_valid && op == 3'd1;
    assign dec_call = instr_valid && op == 3'd2;
    assign dec_ret = instr_valid && op == 3'd3;
    assign dec_interrupt_return = instr_valid && op == 3'd4;
    assign dec_skip = instr_valid && op == 3'd5;
    assign dec_pcl_wr = instr_valid && op == 3'd6;
    assign dec_pcl_data = instr[7:0];
    assign dec_target = instr[12:0];
endmodule
`default_nettype wire

// file: testbench/tb_instruction_sequencer_pc_stack.sv
// Purpose: directed test of fetch order, stack and page jumps
// Assumes: apb slave answers with pready, memory model as partner
// Notes: fetch addresses are logged at every memory strobe
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module tb_instruction_sequencer_pc_stack;
    import iseq_pkg::*;
    // ========
    // signals
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, pm_rd, instr_valid, irq_ack, interrupt_return_done, irq_req = 1'b0;
    logic [PC_W-1:0] pm_addr, dec_target, irq_vector = 13'h1F00;
    logic [INSTR_W-1:0] pm_data, instr;
    logic [1:0] phase, ph0;
    logic [7:0] pc_low_byte, dec_pcl_data;
    logic dec_jump, dec_call, dec_ret, dec_interrupt_return, dec_skip, dec_pcl_wr;
    logic [PC_W-1:0] fq[$];
    logic [PC_W-1:0] exp1 [15] = '{13'h0, 13'h1, 13'h2, 13'h10, 13'h11, 13'h12, 13'h13,
        13'h40, 13'h41, 13'h2, 13'h3, 13'h1FFE, 13'h1FFF, 13'h0, 13'h1};
    int bad_count = 0, num_checks = 0, cyc = 0, acks = 0;
    iseq_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pm_addr, .pm_rd, .pm_data, .instr, .instr_valid, .phase,
        .pc_low_byte, .dec_jump, .dec_call, .dec_ret, .dec_interrupt_return, .dec_skip, .dec_pcl_wr,
        .dec_pcl_data, .dec_target, .irq_req, .irq_vector, .irq_ack, .interrupt_return_done);
    iseq_partner p_i (.pclk, .pm_addr, .pm_data, .instr, .instr_valid, .dec_jump,
        .dec_call, .dec_ret, .dec_interrupt_return, .dec_skip, .dec_pcl_wr, .dec_pcl_data, .dec_target);
    always #12.5 pclk = ~pclk;
    // ========
    // monitor and hang guard
    always @(posedge pclk) begin
        cyc++;
        if (pm_rd === 1'b1) fq.push_back(pm_addr);
        if (irq_ack === 1'b1) acks++;
        if (cyc == 6000) begin
            bad_count++;
            test_done();
        end
    end
    // ========
    // tasks
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        fq.delete();
        presetn <= 1'b1;
    endtask
    // waits for a fetch of one address; cleared log avoids stale hits
    task automatic wait_fetch(input logic [PC_W-1:0] a);
        int n;
        n = 0;
        fq.delete();
        while (n < 300 && !(fq.size() > 0 && fq[$] === a)) begin
            @(posedge pclk);
            n++;
        end
        `CHK(fq[$], a)
    endtask
    // ========
    // sequence: call, skip, low byte jump, interrupt_return, jump to top, wrap
    initial begin
        for (int i = 0; i < 8192; i++) p_i.mem[i] = 16'h0000;
        p_i.mem[1] = 16'h4010;
        p_i.mem[2] = 16'h3FFE;
        p_i.mem[16] = 16'hA000;
        p_i.mem[18] = 16'hC040;
        p_i.mem[64] = 16'h8000;
        do_reset();
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[4:0], 5'h00)
        repeat (100) @(posedge pclk);
        foreach (exp1[i]) `CHK(fq[i], exp1[i])
        // nine nested calls on eight levels, then an interrupt while full
        for (int i = 0; i < 8192; i++) p_i.mem[i] = 16'h0000;
        for (int k = 0; k < 9; k++) p_i.mem[k * 256] = 16'(16'h4000 + (k + 1) * 256);
        p_i.mem[13'h900] = 16'h2900;
        p_i.mem[13'h1F00] = 16'h3F00;
        p_i.mem[13'h1F55] = 16'h3F55;
        do_reset();
        repeat (150) @(posedge pclk);
        irq_req <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[6:0], 7'h78)
        `CHK(acks, 0)
        p_i.mem[13'h900] = 16'h6000;
        wait_fetch(13'h1F00);
        irq_req <= 1'b0;
        `CHK(acks, 1)
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[4:0], 5'h18)
        apb(1'b1, ADDR_PCL, 32'h55);
        wait_fetch(13'h1F55);
        apb(1'b0, ADDR_PC, 32'h0);
        `CHK(rd[12:8], 5'h1F)
        apb(1'b0, ADDR_PCL, 32'h0);
        `CHK(rd[31:8], 24'h0)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        // plain words only, so a frozen phase never holds a flow control
        p_i.mem[13'h1F55] = 16'h0000;
        repeat (12) @(posedge pclk);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd[0], 1'b0)
        apb(1'b0, ADDR_STAT, 32'h0);
        ph0 = rd[9:8];
        repeat (3) @(posedge pclk);
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[9:8], ph0)
        apb(1'b1, ADDR_CTRL, 32'h1);
        test_done();
    end
endmodule
`default_nettype wire
